/* pkg/bit_layer_pkg.sv */
// constants and types for the two-wire bit and byte layer
// assumes a 200 MHz system clock and a bus clock supplied by the master
package bit_layer_pkg;
    localparam int CLOCK_PERIOD_NS      = 5;
    // input_glitch_filter_width per speed grade, ns
    localparam int GLITCH_NS_SLOW       = 100;
    localparam int GLITCH_NS_FAST       = 50;
    // a pulse of exactly the width must still be ignored
    localparam int GLITCH_CYC_SLOW      = GLITCH_NS_SLOW / CLOCK_PERIOD_NS + 1;
    localparam int GLITCH_CYC_FAST      = GLITCH_NS_FAST / CLOCK_PERIOD_NS + 1;
    localparam int FILT_W               = 5;
    localparam int BYTE_W               = 8;
    localparam int CNT_W                = 3;
    localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [CNT_W-1:0] FIRST_BIT = 3'h0;
    localparam int FIFO_DEPTH           = 8;
    localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'hff;
    localparam int SYNC_LEN             = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BITS = 2'b01,
        ST_ACK  = 2'b11,
        ST_MACK = 2'b10
    } bus_state_t;
endpackage

/* pkg/byte_stream_if.sv */
// valid/ready byte stream between the bit layer and its buffer
// assumes both ends run on the same system clock
interface byte_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

/* verilog/byte_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock; i_rst asynchronous active high
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic    i_clock,
    input  wire logic    i_rst,
    // fill and drain sides
    byte_stream_if.snk   fill,
    byte_stream_if.src   drain
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 count;
    } fifo_t;

    fifo_t st_r;
    fifo_t st_nxt;
    logic  do_push;
    logic  do_pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign fill.ready  = (st_r.count != (AW+1)'(DEPTH));
    assign drain.valid = (st_r.count != '0);
    assign drain.data  = st_r.mem[st_r.rp];
    assign do_push     = fill.valid && fill.ready;
    assign do_pop      = drain.valid && drain.ready;

    always_comb begin
        st_nxt = st_r;
        if (do_push) begin
            st_nxt.mem[st_r.wp] = fill.data;
            st_nxt.wp = bump(st_r.wp);
        end
        if (do_pop) begin
            st_nxt.rp = bump(st_r.rp);
        end
        case ({do_push, do_pop})
            2'b10:   st_nxt.count = st_r.count + 1'b1;
            2'b01:   st_nxt.count = st_r.count - 1'b1;
            default: st_nxt.count = st_r.count;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

/* verilog/bit_layer.sv */
// bit and byte layer of a two-wire serial slave
// assumes the master drives the bus clock; sda is open drain outside
// Function
// RULE_01: bits are sampled at the bus clock rise and our output changes at its fall.
// RULE_02: each byte moves most significant bit first, one bit per clock.
// RULE_03: after eight bits the receiver answers ack or nack in a ninth clock.
// RULE_04: a byte is exactly nine clocks with no idle clocks inside.
// RULE_05: the driver of sda changes it only while the clock is low.
// RULE_06: an sda change while the clock is high is a start or a stop.
// RULE_07: any number of bytes may pass between start and stop.
// RULE_08: the bus is idle only with both lines high; nobody holds a line low then.
// RULE_09: the master starts every transfer and supplies the clock.
// RULE_10: data moves both ways on the single sda line, clocked by the master.
// RULE_11: pulses up to 100 ns (50 ns in the fast grade) on both inputs are ignored.
// RULE_12: below the reset threshold the bus is ignored; above it we enter standby.
// RULE_13: the master waits 100 us after stable supply before its first command.
// RULE_14: a start is sda falling with clock high; nothing is answered before one.
// RULE_15: a stop is sda rising with clock high; it ends the transfer into standby.
// RULE_16: the sender frees sda at the eighth fall; the receiver holds it low over the ninth high.
// RULE_17: a start or stop inside a byte discards it and restarts the bit count.
module bit_layer #(
    parameter int FIFO_W = bit_layer_pkg::BYTE_W,
    parameter int FIFO_D = bit_layer_pkg::FIFO_DEPTH
) (
    // system clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    // bus clock as its own domain
    input  wire logic              i_scl_clk,
    // bus pins
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda_o,
    output logic                   o_sda_oe,
    // supply and grade
    input  wire logic              i_supply_ok,
    input  wire logic              i_fast_grade,
    // received bytes
    output logic [FIFO_W-1:0]      o_rx_data,
    output logic                   o_rx_valid,
    input  wire logic              i_rx_ready,
    // bytes to send
    input  wire logic              i_tx_mode,
    input  wire logic [FIFO_W-1:0] i_tx_data,
    input  wire logic              i_tx_valid,
    output logic                   o_tx_ready,
    // status
    output logic                   o_standby,
    output logic                   o_start,
    output logic                   o_stop,
    output logic                   o_master_nack
);
    localparam int SL = bit_layer_pkg::SYNC_LEN;
    localparam int FW = bit_layer_pkg::FILT_W;
    localparam int BW = bit_layer_pkg::BYTE_W;
    localparam int CW = bit_layer_pkg::CNT_W;

    typedef struct packed {
        logic [SL-1:0]            scl_s;
        logic [SL-1:0]            sda_s;
        logic [SL-1:0]            sup_s;
        logic [FW-1:0]            scl_n;
        logic [FW-1:0]            sda_n;
        logic                     scl_f;
        logic                     sda_f;
        bit_layer_pkg::bus_state_t st;
        logic [CW-1:0]            cnt;
        logic [BW-1:0]            sh;
        logic                     drive_req;
        logic                     push;
        logic [BW-1:0]            push_data;
        logic                     tx_take;
        logic                     start_p;
        logic                     stop_p;
        logic                     nack_p;
    } core_t;

    typedef struct packed {
        logic sda_oe;
    } link_t;

    core_t st_r;
    core_t st_nxt;
    link_t lk_r;
    link_t lk_nxt;

    logic [FW-1:0] glitch_cyc;
    logic          scl_rise;
    logic          scl_fall;
    logic          sda_rise;
    logic          sda_fall;
    logic          supply_up;
    logic          i_tx_mode_r;

    byte_stream_if #(.W(FIFO_W)) fill_s ();
    byte_stream_if #(.W(FIFO_W)) drain_s ();

    byte_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .fill    (fill_s),
        .drain   (drain_s)
    );

    assign fill_s.data    = st_r.push_data;
    assign fill_s.valid   = st_r.push;
    assign o_rx_data      = drain_s.data;
    assign o_rx_valid     = drain_s.valid;
    assign drain_s.ready  = i_rx_ready;

    // filter step: follow a change once it outlasts the spike width
    function automatic logic [FW:0] filt(input logic agreed,
                                         input logic cur,
                                         input logic [FW-1:0] n,
                                         input logic [FW-1:0] lim);
        logic [FW-1:0] n1;
        n1 = n + 1'b1;
        if (agreed == cur) begin
            filt = {cur, {FW{1'b0}}};
        end else if (n1 >= lim) begin
            filt = {agreed, {FW{1'b0}}};
        end else begin
            filt = {cur, n1};
        end
    endfunction

    // synchronised value counts when stages two and three agree
    function automatic logic agreed_of(input logic [SL-1:0] s, input logic cur);
        agreed_of = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    assign glitch_cyc = i_fast_grade ? FW'(bit_layer_pkg::GLITCH_CYC_FAST)
                                     : FW'(bit_layer_pkg::GLITCH_CYC_SLOW); // RULE_11

    assign scl_rise  = st_nxt.scl_f && !st_r.scl_f;
    assign scl_fall  = !st_nxt.scl_f && st_r.scl_f;
    assign sda_rise  = st_nxt.sda_f && !st_r.sda_f;
    assign sda_fall  = !st_nxt.sda_f && st_r.sda_f;
    assign supply_up = agreed_of(st_r.sup_s, 1'b0);

    always_comb begin
        logic [FW:0] fs;
        logic [FW:0] fd;
        fs = '0;
        fd = '0;
        st_nxt = st_r;
        st_nxt.push    = 1'b0;
        st_nxt.tx_take = 1'b0;
        st_nxt.start_p = 1'b0;
        st_nxt.stop_p  = 1'b0;
        st_nxt.nack_p  = 1'b0;
        st_nxt.scl_s = {st_r.scl_s[SL-2:0], i_scl};
        st_nxt.sda_s = {st_r.sda_s[SL-2:0], i_sda};
        st_nxt.sup_s = {st_r.sup_s[SL-2:0], i_supply_ok};
        fs = filt(agreed_of(st_r.scl_s, st_r.scl_f), st_r.scl_f,
                  st_r.scl_n, glitch_cyc); // RULE_11
        fd = filt(agreed_of(st_r.sda_s, st_r.sda_f), st_r.sda_f,
                  st_r.sda_n, glitch_cyc); // RULE_11
        st_nxt.scl_f = fs[FW];
        st_nxt.scl_n = fs[FW-1:0];
        st_nxt.sda_f = fd[FW];
        st_nxt.sda_n = fd[FW-1:0];

        if (!supply_up) begin
            // held in reset: bus ignored, sda released
            st_nxt.st        = bit_layer_pkg::ST_IDLE; // RULE_12
            st_nxt.drive_req = 1'b0;
            st_nxt.cnt       = bit_layer_pkg::FIRST_BIT;
        end else if (st_r.scl_f && st_nxt.scl_f && sda_fall) begin
            // start, also repeated start mid-byte
            st_nxt.st        = bit_layer_pkg::ST_BITS; // RULE_14 RULE_06
            st_nxt.cnt       = bit_layer_pkg::FIRST_BIT; // RULE_17
            st_nxt.drive_req = 1'b0;
            st_nxt.start_p   = 1'b1;
        end else if (st_r.scl_f && st_nxt.scl_f && sda_rise) begin
            st_nxt.st        = bit_layer_pkg::ST_IDLE; // RULE_15 RULE_06
            st_nxt.cnt       = bit_layer_pkg::FIRST_BIT; // RULE_17
            st_nxt.drive_req = 1'b0;
            st_nxt.stop_p    = 1'b1;
        end else if (scl_rise) begin
            // sampling at the filtered clock rise
            case (st_r.st) // RULE_01
                bit_layer_pkg::ST_BITS: begin
                    if (!i_tx_mode_r) begin
                        st_nxt.sh = {st_r.sh[BW-2:0], st_r.sda_f}; // RULE_02
                    end else begin
                        st_nxt.sh = {st_r.sh[BW-2:0], 1'b1}; // RULE_02
                    end
                    st_nxt.cnt = st_r.cnt + 1'b1;
                    if (st_r.cnt == bit_layer_pkg::LAST_BIT) begin
                        st_nxt.cnt = bit_layer_pkg::FIRST_BIT;
                        if (i_tx_mode_r) begin
                            // free sda for the master's answer
                            st_nxt.drive_req = 1'b0; // RULE_16
                            st_nxt.st = bit_layer_pkg::ST_MACK; // RULE_03
                        end else begin
                            st_nxt.push      = fill_s.ready;
                            st_nxt.push_data = {st_r.sh[BW-2:0], st_r.sda_f};
                            // ack only when the buffer takes the byte
                            st_nxt.drive_req = fill_s.ready; // RULE_03 RULE_16
                            st_nxt.st = bit_layer_pkg::ST_ACK; // RULE_04
                        end
                    end else if (i_tx_mode_r) begin
                        st_nxt.drive_req = !st_r.sh[BW-2]; // RULE_05 RULE_02
                    end
                end
                bit_layer_pkg::ST_ACK: begin
                    // ninth clock ends: release unless a tx byte's first bit is low, next byte follows at once
                    st_nxt.st = bit_layer_pkg::ST_BITS; // RULE_04 RULE_07
                    st_nxt.drive_req = 1'b0; // RULE_16
                    if (i_tx_mode) begin
                        st_nxt.sh = i_tx_valid ? i_tx_data : bit_layer_pkg::IDLE_BYTE;
                        st_nxt.tx_take = i_tx_valid;
                        st_nxt.drive_req = i_tx_valid && !i_tx_data[BW-1]; // RULE_10
                    end
                end
                bit_layer_pkg::ST_MACK: begin
                    if (st_r.sda_f) begin
                        // master nack: stay off the bus until start/stop
                        st_nxt.st = bit_layer_pkg::ST_IDLE; // RULE_08
                        st_nxt.nack_p = 1'b1;
                    end else begin
                        st_nxt.st = bit_layer_pkg::ST_BITS; // RULE_07
                        st_nxt.sh = i_tx_valid ? i_tx_data : bit_layer_pkg::IDLE_BYTE;
                        st_nxt.tx_take = i_tx_valid;
                        st_nxt.drive_req = i_tx_valid && !i_tx_data[BW-1]; // RULE_10
                    end
                end
                default: begin
                    st_nxt.drive_req = 1'b0; // RULE_14
                end
            endcase
        end
    end

    // transmit direction is fixed for the byte by the ack cycle; a start forces receive for the first byte
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            i_tx_mode_r <= 1'b0;
        end else if (st_nxt.start_p) begin
            i_tx_mode_r <= 1'b0;
        end else if (scl_rise && st_r.st != bit_layer_pkg::ST_BITS) begin
            i_tx_mode_r <= i_tx_mode;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_r       <= '0;
            st_r.scl_f <= 1'b1;
            st_r.sda_f <= 1'b1;
            st_r.st    <= bit_layer_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // link domain: sda changes only at the bus clock fall
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.sda_oe = st_r.drive_req; // RULE_01 RULE_05
    end

    // drive_req is set mid clock-high and stays put across the fall
    always_ff @(negedge i_scl_clk or posedge i_rst) begin
        if (i_rst) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt; // RULE_10
        end
    end

    assign o_sda_o       = 1'b0;
    assign o_sda_oe      = lk_r.sda_oe;
    assign o_tx_ready    = st_r.tx_take;
    assign o_standby     = (st_r.st == bit_layer_pkg::ST_IDLE) && supply_up; // RULE_12
    assign o_start       = st_r.start_p;
    assign o_stop        = st_r.stop_p;
    assign o_master_nack = st_r.nack_p;
endmodule

/* test/bit_layer_chk.sv */
// assertions on the bit layer pins and status pulses
// bound to bit_layer; scl and sda seen as raw pins
module bit_layer_chk (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // bus and supply
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_supply_ok,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    // status
    input wire logic o_start,
    input wire logic o_stop,
    input wire logic o_standby,
    input wire logic o_tx_ready,
    input wire logic o_rx_valid,
    input wire logic o_master_nack
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    oe_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda drive changed with scl high");
    drive_low_a: assert property (o_sda_oe |-> !o_sda_o && !i_sda)
        else $error("driven sda not low");
    idle_free_a: assert property (o_standby |-> !o_sda_oe)
        else $error("sda held in standby");
    por_quiet_a: assert property (!i_supply_ok [*8] |-> !o_sda_oe && !o_start && !o_standby)
        else $error("activity below supply threshold");
    start_cond_a: assert property (o_start |-> i_scl && !i_sda)
        else $error("start without sda low under scl high");
    start_wake_a: assert property (o_start |-> ##[1:2] !o_standby)
        else $error("start left device in standby");
    stop_cond_a: assert property (o_stop |-> i_scl && i_sda)
        else $error("stop without sda high under scl high");
    stop_idle_a: assert property (o_stop |-> ##[0:4] o_standby)
        else $error("stop did not return to standby");
    nack_cond_a: assert property (o_master_nack |-> i_scl && i_sda && !o_sda_oe)
        else $error("master nack flagged wrongly");
    tx_take_a: assert property (o_tx_ready |-> i_scl ##1 !o_tx_ready)
        else $error("tx byte taken outside scl high");
    push_hi_a: assert property ($rose(o_rx_valid) |-> i_scl)
        else $error("rx byte pushed outside scl high");
endmodule
bind bit_layer bit_layer_chk u_chk (.i_clock, .i_rst, .i_scl, .i_sda, .i_supply_ok,
    .o_sda_o, .o_sda_oe, .o_start, .o_stop, .o_standby, .o_tx_ready, .o_rx_valid,
    .o_master_nack);

/* test/bus_master_model.sv */
// two-wire bus master: drives scl and pulls sda low via an enable
// assumes an open-drain sda with pull-up resolved by the bench
module bus_master_model (
    // pacing clock
    input  wire logic i_clock,
    // bus
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    int q = 60;
    int spike = 0;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic start();
        o_sda_oe = 1'b0;
        wt(q);
        o_scl = 1'b1;
        wt(2 * q);
        o_sda_oe = 1'b1;
        wt(2 * q);
        o_scl = 1'b0;
        wt(q);
    endtask
    task automatic bit_io(input logic b, output logic s);
        o_sda_oe = ~b;
        wt(q);
        o_scl = 1'b1;
        wt(q);
        s = i_sda;
        if (spike > 0) begin
            o_sda_oe = ~o_sda_oe;
            wt(spike);
            o_sda_oe = ~o_sda_oe;
        end
        wt(q);
        o_scl = 1'b0;
        wt(q);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(ack, a);
    endtask
    task automatic stop();
        o_sda_oe = 1'b1;
        wt(q);
        o_scl = 1'b1;
        wt(2 * q);
        o_sda_oe = 1'b0;
        wt(4 * q);
    endtask
endmodule

/* test/tb_serial_memory_bus_bit_layer.sv */
// self-checking bench of the bit layer against a bus master model
// assumes scl also serves as the design's bus clock port
module tb_serial_memory_bus_bit_layer;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_clock = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_supply_ok = 1'b0;
    logic       i_fast_grade = 1'b0;
    logic       i_rx_ready = 1'b0;
    logic       i_tx_mode = 1'b0;
    logic       i_tx_valid = 1'b0;
    logic [7:0] i_tx_data = 8'h00;
    logic [7:0] o_rx_data;
    logic       o_sda_o, o_sda_oe, o_rx_valid, o_tx_ready;
    logic       o_standby, o_start, o_stop, o_master_nack;
    logic       scl, m_oe;
    logic [7:0] n_start = 8'h00, n_stop = 8'h00, n_nack = 8'h00, n_txr = 8'h00;
    int         err_total = 0;
    int         checks = 0;
    wire        sda = (m_oe | (o_sda_oe & ~o_sda_o)) ? 1'b0 : 1'b1;
    always #2.5 i_clock = ~i_clock;
    bit_layer dut (.i_clock, .i_rst, .i_scl_clk(scl), .i_scl(scl), .i_sda(sda),
        .o_sda_o, .o_sda_oe, .i_supply_ok, .i_fast_grade, .o_rx_data, .o_rx_valid,
        .i_rx_ready, .i_tx_mode, .i_tx_data, .i_tx_valid, .o_tx_ready, .o_standby,
        .o_start, .o_stop, .o_master_nack);
    bus_master_model mst (.i_clock, .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    always @(posedge i_clock) begin
        n_start <= n_start + {7'h00, o_start === 1'b1};
        n_stop <= n_stop + {7'h00, o_stop === 1'b1};
        n_nack <= n_nack + {7'h00, o_master_nack === 1'b1};
        n_txr <= n_txr + {7'h00, o_tx_ready === 1'b1};
    end
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic clr();
        n_start = 8'h00;
        n_stop = 8'h00;
        n_nack = 8'h00;
        n_txr = 8'h00;
    endtask
    task automatic pop(input logic [7:0] e);
        cmp("rx_valid", 8'h01, {7'h00, o_rx_valid});
        cmp("rx_data", e, o_rx_data);
        i_rx_ready = 1'b1;
        @(negedge i_clock);
        i_rx_ready = 1'b0;
    endtask
    function automatic logic [7:0] pat(input int i);
        return 8'hc3 ^ (8'h01 << i);
    endfunction
    task automatic t_power();
        logic [7:0] r;
        logic a;
        mst.start();
        mst.xfer(8'h5a, 1'b1, r, a);
        mst.stop();
        cmp("ack_off", 8'h01, {7'h00, a});
        cmp("start_off", 8'h00, n_start);
        i_supply_ok = 1'b1;
        mst.wt(20000);
        cmp("standby", 8'h01, {7'h00, o_standby});
    endtask
    task automatic t_fill();
        logic [7:0] r;
        logic a;
        clr();
        mst.start();
        cmp("start", 8'h01, n_start);
        for (int i = 0; i < 9; i++) begin
            mst.xfer(pat(i), 1'b1, r, a);
            cmp("ack", {7'h00, i == 8}, {7'h00, a});
        end
        mst.stop();
        cmp("stop", 8'h01, n_stop);
        cmp("standby", 8'h01, {7'h00, o_standby});
        for (int i = 0; i < 8; i++) pop(pat(i));
        cmp("rx_empty", 8'h00, {7'h00, o_rx_valid});
    endtask
    task automatic t_read();
        logic [7:0] r;
        logic a;
        clr();
        i_tx_mode = 1'b1;
        i_tx_data = 8'h96;
        i_tx_valid = 1'b1;
        mst.start();
        mst.xfer(8'ha1, 1'b1, r, a);
        cmp("first_ack", 8'h00, {7'h00, a});
        cmp("tx_taken", 8'h01, n_txr);
        i_tx_data = 8'h3c;
        pop(8'ha1);
        mst.xfer(8'hff, 1'b0, r, a);
        cmp("rd0", 8'h96, r);
        mst.xfer(8'hff, 1'b1, r, a);
        cmp("rd1", 8'h3c, r);
        cmp("nack", 8'h01, n_nack);
        i_tx_mode = 1'b0;
        i_tx_valid = 1'b0;
        mst.stop();
    endtask
    task automatic t_abort();
        logic [7:0] r;
        logic a;
        clr();
        mst.start();
        repeat (3) mst.bit_io(1'b1, a);
        mst.start();
        mst.xfer(8'h81, 1'b1, r, a);
        mst.stop();
        cmp("abort_ack", 8'h00, {7'h00, a});
        pop(8'h81);
        cmp("rx_empty", 8'h00, {7'h00, o_rx_valid});
        cmp("starts", 8'h02, n_start);
    endtask
    task automatic t_glitch();
        logic [7:0] r;
        logic a;
        for (int g = 0; g < 2; g++) begin
            clr();
            i_fast_grade = g[0];
            mst.spike = g ? 10 : 20;
            mst.start();
            mst.xfer(8'h6b ^ g[7:0], 1'b1, r, a);
            mst.spike = 0;
            mst.stop();
            pop(8'h6b ^ g[7:0]);
            cmp("g_start", 8'h01, n_start);
            cmp("g_stop", 8'h01, n_stop);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        i_rst = 1'b0;
        t_power();
        t_fill();
        t_read();
        t_abort();
        t_glitch();
        end_of_test();
    end
    initial begin
        #450000;
        err_total++;
        end_of_test();
    end
endmodule
